//--- core/measurement_sequencer_calc_engine.v
`include "meas_seq_map.vh"
`default_nettype none
module measurement_sequencer_calc_engine #(
    parameter [31:0] DELAY_STEP_CYC = `DELAY_STEP_CYC,
    parameter [31:0] CYC_PER_US     = `CLK_MHZ
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [19:0] sample_data,
    output reg         convert_start,
    output reg  [1:0]  convert_input,
    output reg         conversion_active
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_DELAY = 3'd1;
    localparam [2:0] ST_CONV  = 3'd2;
    localparam [2:0] ST_NEXT  = 3'd3;
    localparam [1:0] IN_SHUNT = 2'd0;
    localparam [1:0] IN_BUS   = 2'd1;
    localparam [1:0] IN_TEMP  = 2'd2;
    reg  [31:0] adc_setup;
    reg  [31:0] device_config;
    reg  [15:0] shunt_cal;
    reg         conversion_done_flag;
    reg  [19:0] shunt_result;
    reg  [19:0] bus_result;
    reg  [19:0] temp_result;
    reg  [31:0] current;
    reg  [31:0] power;
    reg  [31:0] energy;
    reg  [31:0] charge;
    reg  [31:0] last_current;
    reg  [29:0] acc_shunt;
    reg  [29:0] acc_bus;
    reg  [29:0] acc_temp;
    reg  [29:0] acc_current;
    reg  [10:0] avg_count;
    reg  [2:0]  state;
    reg  [31:0] timer;
    reg  [19:0] sample_meta;
    reg  [19:0] sample_sync;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg         w_held;

    wire [3:0]  mode      = adc_setup[`MODE_MSB:`MODE_LSB];
    wire [2:0]  avg_code  = adc_setup[`AVG_LSB+2:`AVG_LSB];
    wire [7:0]  delay_fld = device_config[`DLY_MSB:`DLY_LSB];
    wire        do_write  = aw_held && w_held && !s_axi_bvalid;
    wire        do_read   = s_axi_arvalid && s_axi_arready;
    wire        wr_setup  = do_write && (aw_addr == `OFS_ADC_SETUP);
    wire        rd_diag   = do_read && (s_axi_araddr == `OFS_DIAG_STATUS);

    // Conversion time of one input, from its own setup field, in clock cycles.
    function [31:0] ct_cycles;
        input [15:0] setup;
        input [1:0]  which;
        reg   [2:0]  code;
        reg   [31:0] us;
        begin
            code = (which == IN_SHUNT) ? setup[`SHUNT_CT_LSB+2:`SHUNT_CT_LSB] :
                   (which == IN_BUS)   ? setup[`BUS_CT_LSB+2:`BUS_CT_LSB] :
                                         setup[`TEMP_CT_LSB+2:`TEMP_CT_LSB];
            us = 32'd0;
            case (code)
                3'd0: us = 32'd50;
                3'd1: us = 32'd84;
                3'd2: us = 32'd150;
                3'd3: us = 32'd280;
                3'd4: us = 32'd540;
                3'd5: us = 32'd1052;
                3'd6: us = 32'd2074;
                default: us = `CT_MAX_US;
            endcase
            ct_cycles = us * CYC_PER_US;
        end
    endfunction

    // Averaging code to sample count, 1 up to 1024.
    function [10:0] avg_total;
        input [2:0] code;
        begin
            case (code)
                3'd0: avg_total = 11'd1;
                3'd1: avg_total = 11'd4;
                3'd2: avg_total = 11'd16;
                3'd3: avg_total = 11'd64;
                3'd4: avg_total = 11'd128;
                3'd5: avg_total = 11'd256;
                3'd6: avg_total = 11'd512;
                default: avg_total = 11'd1024;
            endcase
        end
    endfunction

    // Shift equal to log2 of the averaging count.
    function [3:0] avg_shift;
        input [2:0] code;
        begin
            case (code)
                3'd0: avg_shift = 4'd0;
                3'd1: avg_shift = 4'd2;
                3'd2: avg_shift = 4'd4;
                3'd3: avg_shift = 4'd6;
                3'd4: avg_shift = 4'd7;
                3'd5: avg_shift = 4'd8;
                3'd6: avg_shift = 4'd9;
                default: avg_shift = 4'd10;
            endcase
        end
    endfunction

    // First enabled input at or after a position, in shunt, bus, temp order.
    function [2:0] next_input;
        input [2:0] en;
        input [1:0] from;
        begin
            if (from == IN_SHUNT && en[`MODE_SHUNT_BIT])
                next_input = {1'b1, IN_SHUNT};
            else if (from <= IN_BUS && en[`MODE_BUS_BIT])
                next_input = {1'b1, IN_BUS};
            else if (en[`MODE_TEMP_BIT])
                next_input = {1'b1, IN_TEMP};
            else
                next_input = 3'b000;
        end
    endfunction

    // Product last shunt current times bus sample; truncated on purpose to 32 bits.
    wire [31:0] cur_now  = {{12{sample_sync[19]}}, sample_sync};
    wire [47:0] pwr_prod = last_current[23:0] * {4'h0, sample_sync};
    wire        cal_zero = (shunt_cal == 16'h0000);
    wire [2:0]  first_in = next_input(mode[2:0], IN_SHUNT);
    wire [2:0]  after_in = next_input(mode[2:0], convert_input + 2'd1);
    wire        last_avg = (avg_count + 11'd1 >= avg_total(avg_code));
    wire [29:0] cur_ext  = {{10{sample_sync[19]}}, sample_sync};
    wire [29:0] acc_cur_n = acc_current + cur_ext;
    wire [29:0] acc_bus_n = acc_bus + cur_ext;
    wire [29:0] avg_sh_v  = $signed(acc_shunt) >>> avg_shift(avg_code);
    wire [29:0] avg_cur_v = $signed(acc_current) >>> avg_shift(avg_code);
    wire [29:0] avg_bus_v = $signed(acc_bus) >>> avg_shift(avg_code);
    wire [29:0] avg_tmp_v = $signed(acc_temp) >>> avg_shift(avg_code);
    wire [47:0] avg_prod  = avg_cur_v[23:0] * {4'h0, avg_bus_v[19:0]};

    always @(posedge aclk) begin
        sample_meta <= sample_data;
        sample_sync <= sample_meta;
    end

    // AXI4-Lite slave: address and data taken in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            adc_setup     <= `ADC_SETUP_RESET;
            device_config <= 32'h0000_0000;
            shunt_cal     <= 16'h0000;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready;
            s_axi_wready  <= !w_held && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= 2'b00;
                case (aw_addr)
                    `OFS_ADC_SETUP:     adc_setup <= {16'h0000, w_data[15:0]};
                    `OFS_DEVICE_CONFIG: device_config <= {18'h0, w_data[`DLY_MSB:`DLY_LSB],
                                                          6'h00};
                    `OFS_SHUNT_CAL:     shunt_cal <= w_data[15:0];
                    default:            s_axi_bresp <= 2'b10;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (do_read) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= 2'b00;
                case (s_axi_araddr)
                    `OFS_ADC_SETUP:     s_axi_rdata <= adc_setup;
                    `OFS_DEVICE_CONFIG: s_axi_rdata <= device_config;
                    `OFS_SHUNT_CAL:     s_axi_rdata <= {16'h0000, shunt_cal};
                    `OFS_DIAG_STATUS:   s_axi_rdata <= {30'h0, conversion_done_flag, 1'b0};
                    `OFS_SHUNT_RESULT:  s_axi_rdata <= {12'h000, shunt_result};
                    `OFS_BUS_RESULT:    s_axi_rdata <= {12'h000, bus_result};
                    `OFS_TEMP_RESULT:   s_axi_rdata <= {12'h000, temp_result};
                    `OFS_CURRENT:       s_axi_rdata <= current;
                    `OFS_POWER:         s_axi_rdata <= power;
                    `OFS_ENERGY:        s_axi_rdata <= energy;
                    `OFS_CHARGE:        s_axi_rdata <= charge;
                    `OFS_SEQ_STATUS:    s_axi_rdata <= {21'h0, avg_count};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Sequencer. Sample data is taken as the converter result at the end of each slot.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            timer <= 32'h0000_0000;
            convert_start <= 1'b0;
            convert_input <= IN_SHUNT;
            conversion_active <= 1'b0;
            conversion_done_flag <= 1'b0;
            avg_count <= 11'd0;
            acc_shunt <= 30'h0;
            acc_bus <= 30'h0;
            acc_temp <= 30'h0;
            acc_current <= 30'h0;
            shunt_result <= 20'h00000;
            bus_result <= 20'h00000;
            temp_result <= 20'h00000;
            current <= 32'h0000_0000;
            last_current <= 32'h0000_0000;
            power <= 32'h0000_0000;
            energy <= 32'h0000_0000;
            charge <= 32'h0000_0000;
        end else begin
            convert_start <= 1'b0;
            if (wr_setup) begin
                // A setup write wins over a completion in the same cycle.
                if (w_data[2:0] != 3'b000)
                    conversion_done_flag <= 1'b0;
                avg_count <= 11'd0;
                acc_shunt <= 30'h0;
                acc_bus <= 30'h0;
                acc_temp <= 30'h0;
                acc_current <= 30'h0;
                timer <= delay_fld * DELAY_STEP_CYC;
                conversion_active <= (w_data[2:0] != 3'b000);
                state <= (w_data[2:0] != 3'b000) ? ST_DELAY : ST_IDLE;
            end else begin
                if (rd_diag)
                    conversion_done_flag <= 1'b0;
                case (state)
                    ST_IDLE: conversion_active <= 1'b0;
                    ST_DELAY: begin
                        if (timer != 32'h0) begin
                            timer <= timer - 32'd1;
                        end else if (first_in[2]) begin
                            convert_input <= first_in[1:0];
                            convert_start <= 1'b1;
                            timer <= ct_cycles(adc_setup[15:0], first_in[1:0]);
                            state <= ST_CONV;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_CONV: begin
                        if (timer > 32'd1) begin
                            timer <= timer - 32'd1;
                        end else begin
                            state <= ST_NEXT;
                            case (convert_input)
                                IN_SHUNT: begin
                                    last_current <= cur_now;
                                    charge <= cal_zero ? 32'h0 : charge + cur_now;
                                    acc_shunt <= acc_cur_n;
                                    acc_current <= acc_cur_n;
                                    if (avg_code == 3'd0) begin
                                        shunt_result <= sample_sync;
                                        current <= cur_now;
                                    end
                                end
                                IN_BUS: begin
                                    energy <= cal_zero ? 32'h0 :
                                              energy + pwr_prod[31:0];
                                    acc_bus <= acc_bus_n;
                                    if (avg_code == 3'd0) begin
                                        bus_result <= sample_sync;
                                        power <= cal_zero ? 32'h0 : pwr_prod[31:0];
                                    end
                                end
                                default: begin
                                    acc_temp <= acc_temp + cur_ext;
                                    if (avg_code == 3'd0)
                                        temp_result <= sample_sync;
                                end
                            endcase
                        end
                    end
                    ST_NEXT: begin
                        if (after_in[2] && convert_input != IN_TEMP) begin
                            convert_input <= after_in[1:0];
                            convert_start <= 1'b1;
                            timer <= ct_cycles(adc_setup[15:0], after_in[1:0]);
                            state <= ST_CONV;
                        end else if (!last_avg) begin
                            avg_count <= avg_count + 11'd1;
                            timer <= 32'h0;
                            state <= ST_DELAY;
                        end else begin
                            if (avg_code != 3'd0) begin
                                shunt_result <= avg_sh_v[19:0];
                                bus_result <= avg_bus_v[19:0];
                                temp_result <= avg_tmp_v[19:0];
                                current <= {{12{avg_cur_v[19]}}, avg_cur_v[19:0]};
                                power <= cal_zero ? 32'h0 : avg_prod[31:0];
                            end
                            conversion_done_flag <= 1'b1;
                            avg_count <= 11'd0;
                            acc_shunt <= 30'h0;
                            acc_bus <= 30'h0;
                            acc_temp <= 30'h0;
                            acc_current <= 30'h0;
                            timer <= 32'h0;
                            if (mode[`MODE_CONT_BIT]) begin
                                state <= ST_DELAY;
                            end else begin
                                state <= ST_IDLE;
                                conversion_active <= 1'b0;
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

//--- core/meas_seq_map.vh
`ifndef MEAS_SEQ_MAP_VH
`define MEAS_SEQ_MAP_VH
// Register byte offsets on the AXI4-Lite port.
`define OFS_ADC_SETUP      8'h00
`define OFS_DEVICE_CONFIG  8'h04
`define OFS_SHUNT_CAL      8'h08
`define OFS_DIAG_STATUS    8'h0c
`define OFS_SHUNT_RESULT   8'h10
`define OFS_BUS_RESULT     8'h14
`define OFS_TEMP_RESULT    8'h18
`define OFS_CURRENT        8'h1c
`define OFS_POWER          8'h20
`define OFS_ENERGY         8'h24
`define OFS_CHARGE         8'h28
`define OFS_SEQ_STATUS     8'h2c
// Converter setup fields: mode[3:0], bus ct[6:4], shunt ct[9:7], temp ct[12:10], avg[15:13].
`define MODE_LSB           0
`define MODE_MSB           3
`define BUS_CT_LSB         4
`define SHUNT_CT_LSB       7
`define TEMP_CT_LSB        10
`define AVG_LSB            13
`define ADC_SETUP_RESET    32'h0000_0fff
// Mode bit 3 selects continuous, bits 2:0 enable temperature, shunt, bus.
`define MODE_CONT_BIT      3
`define MODE_TEMP_BIT      2
`define MODE_SHUNT_BIT     1
`define MODE_BUS_BIT       0
// Device config: start delay field in bits 13:6, in 2 ms steps.
`define DLY_LSB            6
`define DLY_MSB            13
`define DLY_RESET          8'h00
`define DIAG_DONE_BIT      1
// Timing: clock 250 MHz; times given in microseconds.
`define CLK_MHZ            250
`define DELAY_STEP_US      2000
`define CT_MAX_US          4120
`define DELAY_STEP_CYC     (`DELAY_STEP_US * `CLK_MHZ)
`endif

//--- sim/measurement_sequencer_calc_engine_monitor.sv
`default_nettype none
module measurement_sequencer_calc_engine_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        convert_start,
    input wire logic [1:0]  convert_input,
    input wire logic        conversion_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // A sequence that ends with no write nearby must stay ended; the settle
    // window keeps an aborted sequence from looking like a finished one.
    logic       quiet;
    logic [2:0] settle;
    always_ff @(posedge aclk) begin
        if (!aresetn || s_axi_awvalid || s_axi_bvalid) begin
            settle <= 3'd7;
            quiet  <= 1'b0;
        end else begin
            if (settle != 3'd0) settle <= settle - 3'd1;
            if ($fell(conversion_active) && settle == 3'd0) quiet <= 1'b1;
        end
    end
    a_start_spacing: assert property (convert_start |=> !convert_start [*8])
        else $error("conversion slots too close");
    a_start_active: assert property (convert_start |-> conversion_active)
        else $error("slot started outside a sequence");
    a_input_legal: assert property (convert_start |-> convert_input != 2'd3)
        else $error("illegal input selected");
    a_quiet_after: assert property (quiet |-> !convert_start)
        else $error("conversion after sequence end without trigger");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h2c
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !convert_start
        && !conversion_active && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs busy in reset");
    c_seq_end: cover property ($fell(conversion_active));
    c_temp_slot: cover property (convert_start && convert_input == 2'd2);
    c_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule
bind measurement_sequencer_calc_engine measurement_sequencer_calc_engine_monitor i_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .convert_start(convert_start), .convert_input(convert_input),
    .conversion_active(conversion_active));
`default_nettype wire

//--- sim/measurement_sequencer_calc_engine_bench.sv
`default_nettype none
module measurement_sequencer_calc_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STEP = 10;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [19:0] sample_data = 20'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, convert_input;
    logic [31:0] s_axi_rdata, rv;
    logic        convert_start, conversion_active;
    logic [1:0]  rr;
    logic [2:0]  seen;
    logic        fix = 1'b0;
    logic [19:0] fix_val = 20'h0;
    int          fails = 0;
    int          cmp_count = 0;
    int          starts, first, e, d;

    measurement_sequencer_calc_engine #(.DELAY_STEP_CYC(32'(STEP)), .CYC_PER_US(32'd1))
    i_measurement_sequencer_calc_engine (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sample_data(sample_data),
        .convert_start(convert_start), .convert_input(convert_input),
        .conversion_active(conversion_active));

    initial forever #2 aclk = ~aclk;
    always @(posedge aclk) sample_data <= fix ? fix_val : 20'($urandom());

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic timed_out();
        fails++;
        $display("wrong value at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
        complete_run();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        cmp_count++;
        if (got !== want) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (s_axi_bvalid !== 1'b1 && n < 100) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            n++;
        end
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n >= 100) timed_out();
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (s_axi_rvalid !== 1'b1 && n < 100) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            n++;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n >= 100) timed_out();
    endtask

    task automatic count_starts(input int cyc);
        starts = 0;
        repeat (cyc) begin
            @(posedge aclk);
            if (convert_start === 1'b1) starts++;
        end
    endtask

    // Writes the setup word and follows one triggered sequence to its end.
    task automatic run_seq(input logic [31:0] setup);
        int n;
        wr(8'h00, setup);
        seen = 3'b000;
        starts = 0;
        first = -1;
        n = 0;
        while (!(starts > 0 && conversion_active === 1'b0) && n < 40000) begin
            @(posedge aclk);
            if (convert_start === 1'b1) begin
                seen[convert_input] = 1'b1;
                if (starts == 0) first = n;
                starts++;
            end
            n++;
        end
        if (n >= 40000) timed_out();
    endtask

    // Slot inputs: 0 shunt, 1 bus, 2 temperature; mode bits 1, 0, 2 enable them.
    function automatic logic [31:0] exp_seen(input logic [2:0] m);
        return {29'h0, m[2], m[0], m[1]};
    endfunction

    // Power is the averaged current times the averaged bus value, low word kept.
    function automatic logic [31:0] exp_pwr(input logic [19:0] v);
        return 32'(40'(v) * 40'(v));
    endfunction

    initial begin
        void'($urandom(32'hdc6e26e2));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h04);
        check(32'(rv[13:6]), 32'h0);
        wr(8'h00, 32'h0);
        rd(8'h40);
        check({rv[29:0], rr}, 32'h2);
        rd(8'h10);
        d = rv;
        wr(8'h10, $urandom());
        check(32'(rr), 32'h2);
        rd(8'h10);
        check(rv, 32'(d));
        $display("test registers done");
        for (e = 1; e < 8; e++) begin
            run_seq(32'(e));
            check(32'(seen), exp_seen(3'(e)));
            check(32'(starts), 32'($countones(e)));
            check(32'(first <= 40), 32'h1);
            rd(8'h0c);
            check(32'(rv[1]), 32'h1);
            rd(8'h0c);
            check(32'(rv[1]), 32'h0);
            count_starts(300);
            check(32'(starts), 32'h0);
        end
        run_seq(32'h2);
        wr(8'h00, 32'h0);
        rd(8'h0c);
        check(32'(rv[1]), 32'h1);
        wr(8'h00, 32'h7);
        rd(8'h0c);
        check(32'(rv[1]), 32'h0);
        $display("test modes done");
        repeat (8) @(posedge aclk);
        e = 1 + $urandom_range(6);
        run_seq(32'h2000 | e);
        check(32'(starts % $countones(e)), 32'h0);
        check(32'(starts), 32'(4 * $countones(e)));
        $display("test averaging done");
        for (int k = 0; k < 3; k++) begin
            d = (k == 0) ? 1 : 2 + $urandom_range(6);
            wr(8'h04, 32'(d) << 6);
            run_seq(32'h2);
            check(32'(first >= d * STEP && first <= d * STEP + 40), 32'h1);
        end
        wr(8'h04, 32'h0);
        $display("test delay done");
        wr(8'h00, 32'h000a);
        count_starts(1000);
        check(32'(starts > 2), 32'h1);
        wr(8'h00, 32'h0);
        repeat (8) @(posedge aclk);
        wr(8'h00, 32'h038a);
        count_starts(100);
        wr(8'h00, 32'h038a);
        count_starts(40);
        check(32'(starts), 32'h1);
        $display("test continuous done");
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h000b);
        count_starts(1000);
        for (int a = 8'h20; a <= 8'h28; a += 4) begin
            rd(8'(a));
            check(rv, 32'h0);
        end
        $display("test zero calibration done");
        wr(8'h08, 32'h1);
        count_starts(300);
        rd(8'h28);
        d = rv;
        count_starts(300);
        rd(8'h28);
        check(32'(rv != 32'(d)), 32'h1);
        wr(8'h00, 32'h0);
        repeat (8) @(posedge aclk);
        fix_val <= {1'b0, 19'($urandom())};
        fix <= 1'b1;
        run_seq(32'h2007);
        rd(8'h10);
        check(rv, {12'h000, fix_val});
        rd(8'h1c);
        check(rv, {12'h000, fix_val});
        rd(8'h20);
        check(rv, exp_pwr(fix_val));
        $display("test accumulation done");
        complete_run();
    end
endmodule
`default_nettype wire
